// ===== shared/mmpr_pkg.sv
package mmpr_pkg;
   // address regions
   typedef enum logic [7:0] {
      MMPR_REG_IO     = 8'h01,
      MMPR_REG_RAM    = 8'h02,
      MMPR_REG_UNIMP  = 8'h04,
      MMPR_REG_EPROM  = 8'h08,
      MMPR_REG_SYS    = 8'h10,
      MMPR_REG_MON    = 8'h20,
      MMPR_REG_RSVD   = 8'h40,
      MMPR_REG_VECTOR = 8'h80
   } mmpr_region_t;

   localparam logic [15:0] IO_LAST = 16'h004f;
   localparam logic [15:0] RAM_FIRST = 16'h0050;
   localparam logic [15:0] RAM_LAST = 16'h024f;
   localparam logic [15:0] EPROM_FIRST = 16'hbe00;
   localparam logic [15:0] EPROM_LAST = 16'hfdff;
   localparam logic [15:0] SYS_FIRST = 16'hfe00;
   localparam logic [15:0] SYS_LAST = 16'hfe0f;
   localparam logic [15:0] MON_FIRST = 16'hfe10;
   localparam logic [15:0] MON_LAST = 16'hfeff;
   localparam logic [15:0] UNIMP_HI_FIRST = 16'hff00;
   localparam logic [15:0] UNIMP_HI_LAST = 16'hffbf;
   localparam logic [15:0] RSVD_FIRST = 16'hffc0;
   localparam logic [15:0] RSVD_LAST = 16'hffd1;
   localparam logic [15:0] VECTOR_FIRST = 16'hffd2;

   // port register offsets
   localparam logic [15:0] PORT_A_DATA = 16'h0000;
   localparam logic [15:0] PORT_B_DATA = 16'h0001;
   localparam logic [15:0] PORT_C_DATA = 16'h0002;
   localparam logic [15:0] PORT_D_INPUT = 16'h0003;
   localparam logic [15:0] PORT_E_DATA = 16'h0004;
   localparam logic [15:0] PORT_F_DATA = 16'h0005;
   localparam logic [15:0] PORT_A_DIRECTION = 16'h0006;
   localparam logic [15:0] PORT_B_DIRECTION = 16'h0007;
   localparam logic [15:0] PORT_C_DIRECTION = 16'h0008;

   // system register offsets
   localparam logic [15:0] BREAK_STATUS = 16'hfe00;
   localparam logic [15:0] RESET_SOURCE_STATUS = 16'hfe01;
   localparam logic [15:0] BREAK_FLAG_CONTROL = 16'hfe03;
   localparam logic [15:0] PROGRAM_MEMORY_CONTROL = 16'hfe07;
   localparam logic [15:0] CLOCK_MULTIPLIER_CONTROL = 16'hfe0b;
   localparam logic [15:0] CLOCK_MULTIPLIER_BANDWIDTH = 16'hfe0c;
   localparam logic [15:0] CLOCK_MULTIPLIER_PROGRAM = 16'hfe0d;
   localparam logic [15:0] LOW_VOLTAGE_STATUS = 16'hfe0f;
   localparam logic [15:0] WATCHDOG_CONTROL = 16'hffff;

   // implemented bit masks and reset values
   localparam logic [7:0] MASK_7BIT = 8'h7f;
   localparam logic [7:0] MASK_6BIT = 8'h3f;
   localparam logic [7:0] DIRECTION_RESET = 8'h00;

   // system register selects
   typedef enum logic [8:0] {
      MMPR_SYS_NONE   = 9'h000,
      MMPR_SYS_BRKST  = 9'h001,
      MMPR_SYS_RSTSRC = 9'h002,
      MMPR_SYS_BRKFC  = 9'h004,
      MMPR_SYS_PMCTL  = 9'h008,
      MMPR_SYS_CMCTL  = 9'h010,
      MMPR_SYS_CMBW   = 9'h020,
      MMPR_SYS_CMPRG  = 9'h040,
      MMPR_SYS_LVST   = 9'h080,
      MMPR_SYS_WDOG   = 9'h100
   } mmpr_sys_t;
endpackage

// ===== core/mmpr_decoder.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - 16-bit address routes every access to exactly one region.
// - 0000 to 004F is the I/O window; RAM follows directly.
// - BE00-FDFF program memory; RAM 512 bytes at 0050; gap unimplemented.
// - FE10-FEFF monitor ROM; FF00-FFBF unimplemented; FFC0-FFD1 reserved.
// - FFD2 to FFFF selects the vector table.
// - FE00 selects the break status register.
// - FE01 selects the reset-source status register.
// - FE03 break flag control; FE02, FE04-FE06 reserved, empty.
// - FE07 selects the program-memory control register.
// - FE0B, FE0C, FE0D select clock multiplier control, bandwidth, program.
// - FE0F selects the low-voltage status register.
// - FFFF selects watchdog control besides being a vector byte.
// - ports A, B, E latches at 0000, 0001, 0004 survive reset.
// - port C data: bits 6-0 read/write, bit 7 zero, survives reset.
// - port D read-only: bits 6-0 pins, bit 7 zero.
// - port F data: bits 5-0 read/write, bits 7-6 zero, survives reset.
// - port A, B directions fully read/write, cleared on reset.
// - port C direction: bits 6-0 read/write, bit 7 zero, cleared.
module mmpr_decoder (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // processor bus
   input wire logic [15:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   // region decode
   output mmpr_pkg::mmpr_region_t region_o,
   output mmpr_pkg::mmpr_sys_t sys_sel_o,
   output logic illegal_addr_o,
   // data from regions outside this block
   input wire logic [7:0] mem_rdata_i,
   input wire logic [7:0] sys_rdata_i,
   // port pins
   input wire logic [7:0] port_a_pin_i,
   output logic [7:0] port_a_pin_o,
   output logic [7:0] port_a_pin_oe_o,
   input wire logic [7:0] port_b_pin_i,
   output logic [7:0] port_b_pin_o,
   output logic [7:0] port_b_pin_oe_o,
   input wire logic [6:0] port_c_pin_i,
   output logic [6:0] port_c_pin_o,
   output logic [6:0] port_c_pin_oe_o,
   input wire logic [6:0] port_d_pin_i,
   // latches whose pin direction lives elsewhere
   output logic [7:0] port_e_latch_o,
   output logic [5:0] port_f_latch_o
);
   import mmpr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // decode functions
   function automatic mmpr_region_t region_of(input logic [15:0] a);
      mmpr_region_t r;
      r = MMPR_REG_UNIMP;
      if (a <= IO_LAST) begin
         r = MMPR_REG_IO;
      end else if (a >= RAM_FIRST && a <= RAM_LAST) begin
         r = MMPR_REG_RAM;
      end else if (a >= EPROM_FIRST && a <= EPROM_LAST) begin
         r = MMPR_REG_EPROM;
      end else if (a >= SYS_FIRST && a <= SYS_LAST) begin
         r = MMPR_REG_SYS;
      end else if (a >= MON_FIRST && a <= MON_LAST) begin
         r = MMPR_REG_MON;
      end else if (a >= UNIMP_HI_FIRST && a <= UNIMP_HI_LAST) begin
         r = MMPR_REG_UNIMP;
      end else if (a >= RSVD_FIRST && a <= RSVD_LAST) begin
         r = MMPR_REG_RSVD;
      end else if (a >= VECTOR_FIRST) begin
         r = MMPR_REG_VECTOR;
      end
      return r;
   endfunction

   function automatic mmpr_sys_t sys_of(input logic [15:0] a);
      mmpr_sys_t s;
      s = MMPR_SYS_NONE;
      case (a)
         BREAK_STATUS: s = MMPR_SYS_BRKST;
         RESET_SOURCE_STATUS: s = MMPR_SYS_RSTSRC;
         BREAK_FLAG_CONTROL: s = MMPR_SYS_BRKFC;
         PROGRAM_MEMORY_CONTROL: s = MMPR_SYS_PMCTL;
         CLOCK_MULTIPLIER_CONTROL: s = MMPR_SYS_CMCTL;
         CLOCK_MULTIPLIER_BANDWIDTH: s = MMPR_SYS_CMBW;
         CLOCK_MULTIPLIER_PROGRAM: s = MMPR_SYS_CMPRG;
         LOW_VOLTAGE_STATUS: s = MMPR_SYS_LVST;
         WATCHDOG_CONTROL: s = MMPR_SYS_WDOG;
         default: s = MMPR_SYS_NONE;
      endcase
      return s;
   endfunction

   // mixed read of latch and pin
   function automatic logic [7:0] mix(input logic [7:0] dir,
                                      input logic [7:0] lat,
                                      input logic [7:0] pin);
      return (dir & lat) | (~dir & pin);
   endfunction

   // only a mapped offset takes a write
   function automatic logic io_write(input logic wr,
                                     input logic [15:0] a,
                                     input logic [15:0] target);
      return wr && (a == target);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, only the second stage is read
   logic [7:0] a_s1, a_s2;
   logic [7:0] b_s1, b_s2;
   logic [6:0] c_s1, c_s2;
   logic [6:0] d_s1, d_s2;

   // port a pins
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         a_s1 <= 8'h00;
         a_s2 <= 8'h00;
      end else begin
         a_s1 <= port_a_pin_i;
         a_s2 <= a_s1;
      end
   end

   // port b pins
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         b_s1 <= 8'h00;
         b_s2 <= 8'h00;
      end else begin
         b_s1 <= port_b_pin_i;
         b_s2 <= b_s1;
      end
   end

   // port c pins
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         c_s1 <= 7'h00;
         c_s2 <= 7'h00;
      end else begin
         c_s1 <= port_c_pin_i;
         c_s2 <= c_s1;
      end
   end

   // port d pins
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         d_s1 <= 7'h00;
         d_s2 <= 7'h00;
      end else begin
         d_s1 <= port_d_pin_i;
         d_s2 <= d_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // combinational decode
   mmpr_region_t region;
   mmpr_sys_t sys_sel;
   logic access;

   assign region = region_of(addr_i);
   assign sys_sel = sys_of(addr_i);
   assign access = rd_i | wr_i;
   assign region_o = region;
   assign sys_sel_o = sys_sel;
   assign illegal_addr_o = access && (region == MMPR_REG_UNIMP);

   logic wr_io;
   assign wr_io = wr_i && (region == MMPR_REG_IO);

   // one write enable per writable port register; port D has none
   logic wr_pa_data;
   logic wr_pb_data;
   logic wr_pc_data;
   logic wr_pe_data;
   logic wr_pf_data;
   logic wr_pa_dir;
   logic wr_pb_dir;
   logic wr_pc_dir;

   assign wr_pa_data = io_write(wr_io, addr_i, PORT_A_DATA);
   assign wr_pb_data = io_write(wr_io, addr_i, PORT_B_DATA);
   assign wr_pc_data = io_write(wr_io, addr_i, PORT_C_DATA);
   assign wr_pe_data = io_write(wr_io, addr_i, PORT_E_DATA);
   assign wr_pf_data = io_write(wr_io, addr_i, PORT_F_DATA);

   assign wr_pa_dir = io_write(wr_io, addr_i, PORT_A_DIRECTION);
   assign wr_pb_dir = io_write(wr_io, addr_i, PORT_B_DIRECTION);
   assign wr_pc_dir = io_write(wr_io, addr_i, PORT_C_DIRECTION);

   ////////////////////////////////////////////////////////////////////////////
   // data latches, no reset
   logic [7:0] port_a_data;
   logic [7:0] port_b_data;
   logic [7:0] port_e_data;
   logic [6:0] port_c_data;
   logic [5:0] port_f_data;

   always_ff @(posedge core_clk_i) begin
      if (wr_pa_data) begin
         port_a_data <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wr_pb_data) begin
         port_b_data <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wr_pe_data) begin
         port_e_data <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wr_pc_data) begin
         port_c_data <= wdata_i[6:0];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wr_pf_data) begin
         port_f_data <= wdata_i[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // direction registers
   logic [7:0] port_a_direction;
   logic [7:0] port_b_direction;
   logic [6:0] port_c_direction;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_a_direction <= DIRECTION_RESET;
      end else if (wr_pa_dir) begin
         port_a_direction <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_b_direction <= DIRECTION_RESET;
      end else if (wr_pb_dir) begin
         port_b_direction <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_c_direction <= DIRECTION_RESET[6:0];
      end else if (wr_pc_dir) begin
         port_c_direction <= wdata_i[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   // ports a, b, c drive and ports e, f latches
   assign port_a_pin_o = port_a_data;
   assign port_a_pin_oe_o = port_a_direction;
   assign port_b_pin_o = port_b_data;
   assign port_b_pin_oe_o = port_b_direction;
   assign port_c_pin_o = port_c_data;
   assign port_c_pin_oe_o = port_c_direction;
   assign port_e_latch_o = port_e_data;
   assign port_f_latch_o = port_f_data;

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   // latch where driven, pin where floating
   logic [7:0] pa_read;
   logic [7:0] pb_read;
   logic [7:0] pc_read;
   logic [7:0] io_rdata;
   logic [7:0] next_rdata;
   logic sys_hit;

   assign pa_read = mix(port_a_direction, port_a_data, a_s2);
   assign pb_read = mix(port_b_direction, port_b_data, b_s2);
   assign pc_read = MASK_7BIT & mix({1'b0, port_c_direction},
                                    {1'b0, port_c_data}, {1'b0, c_s2});
   // only a named system slot answers
   assign sys_hit = (sys_sel != MMPR_SYS_NONE);

   always_comb begin
      io_rdata = 8'h00;
      case (addr_i)
         PORT_A_DATA: io_rdata = pa_read;
         PORT_B_DATA: io_rdata = pb_read;
         PORT_C_DATA: io_rdata = pc_read;
         PORT_D_INPUT: io_rdata = {1'b0, d_s2};
         PORT_E_DATA: io_rdata = port_e_data;
         PORT_F_DATA: io_rdata = MASK_6BIT & {2'b00, port_f_data};
         PORT_A_DIRECTION: io_rdata = port_a_direction;
         PORT_B_DIRECTION: io_rdata = port_b_direction;
         PORT_C_DIRECTION: io_rdata = {1'b0, port_c_direction};
         default: io_rdata = 8'h00;
      endcase
   end

   always_comb begin
      next_rdata = 8'h00;
      case (region)
         MMPR_REG_IO: next_rdata = io_rdata;
         MMPR_REG_RAM: next_rdata = mem_rdata_i;
         MMPR_REG_EPROM: next_rdata = mem_rdata_i;
         MMPR_REG_MON: next_rdata = mem_rdata_i;
         MMPR_REG_SYS: next_rdata = sys_hit ? sys_rdata_i : 8'h00;
         MMPR_REG_VECTOR: next_rdata = mem_rdata_i;
         default: next_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data register
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end
   end
endmodule

// ===== testbench/mmpr_decoder_monitor.sv
`timescale 1ns/10ps
module mmpr_decoder_monitor (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // bus and decode
   input wire logic [15:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input mmpr_pkg::mmpr_region_t region_o,
   input mmpr_pkg::mmpr_sys_t sys_sel_o,
   input wire logic illegal_addr_o,
   // directions
   input wire logic [7:0] port_a_pin_oe_o,
   input wire logic [6:0] port_c_pin_oe_o
);
   import mmpr_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   ////////////////////////////////////////
   region_onehot_a: assert property ($onehot(region_o))
      else $error("region not one-hot");
   io_window_a: assert property (
      addr_i <= 16'h004f |-> region_o == 8'h01) else $error("io decode");
   ram_range_a: assert property (
      addr_i inside {[16'h0050:16'h024f]} |-> region_o == 8'h02)
      else $error("ram decode");
   gap_range_a: assert property (
      addr_i inside {[16'h0250:16'hbdff]} |-> region_o == 8'h04)
      else $error("gap decode");
   eprom_range_a: assert property (
      addr_i inside {[16'hbe00:16'hfdff]} |-> region_o == 8'h08)
      else $error("eprom decode");
   monitor_range_a: assert property (
      addr_i inside {[16'hfe10:16'hfeff]} |-> region_o == 8'h20)
      else $error("monitor decode");
   vector_range_a: assert property (
      addr_i >= 16'hffd2 |-> region_o == 8'h80) else $error("vector decode");
   watchdog_select_a: assert property (
      addr_i == 16'hffff |-> sys_sel_o == 9'h100) else $error("wdog select");
   illegal_flag_a: assert property (
      illegal_addr_o == ((rd_i || wr_i) && region_o == 8'h04))
      else $error("illegal flag wrong");
   unmapped_read_a: assert property (
      rd_i && addr_i inside {[16'h0009:16'h004f]} |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   dir_a_write_a: assert property (
      wr_i && addr_i == 16'h0006 |=> port_a_pin_oe_o == $past(wdata_i))
      else $error("direction a not written");
   dir_c_write_a: assert property (
      wr_i && addr_i == 16'h0008 |=> port_c_pin_oe_o == $past(wdata_i[6:0]))
      else $error("direction c not written");
endmodule
bind mmpr_decoder mmpr_decoder_monitor mon_u (.core_clk_i, .arst_n_i,
   .addr_i, .rd_i, .wr_i, .wdata_i, .rdata_o, .region_o, .sys_sel_o,
   .illegal_addr_o, .port_a_pin_oe_o, .port_c_pin_oe_o);

// ===== testbench/mmpr_cpu_model.sv
`timescale 1ns/10ps
module mmpr_cpu_model (
   // clock and read data
   input wire logic core_clk_i,
   input wire logic [7:0] rdata_i,
   // bus requests
   output logic [15:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] wdata_o
);
   initial begin
      addr_o = 16'h1234;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 8'h00;
   end
   // released lines show inverse values
   task automatic write_byte(input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge core_clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic read_byte(input logic [15:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge core_clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
   task automatic show_addr(input logic [15:0] a);
      @(negedge core_clk_i);
      addr_o = a;
   endtask
endmodule

// ===== testbench/test_memory_map_port_registers.sv
`timescale 1ns/10ps
module test_memory_map_port_registers;
   import mmpr_pkg::*;
   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] mem_rdata = 8'h99, sys_rdata = 8'hee, pa_ext = 8'h00;
   logic [7:0] pb_ext = 8'h00, rd_v, pa_o, pa_oe, pb_o, pb_oe, pe_o, rdata;
   logic [6:0] pc_ext = 7'h00, pd_pin = 7'h55, pc_o, pc_oe;
   logic [5:0] pf_o;
   logic [15:0] addr;
   logic rd, wr, illegal, ill_q = 1'b0;
   logic [7:0] wdata;
   mmpr_region_t region;
   mmpr_sys_t sys_sel;
   int num_errors = 0, cmp_count = 0, cycles = 0;
   logic [15:0] dec_a [20] = '{16'h004f, 16'h0050, 16'h024f, 16'h0250,
      16'hffd2, 16'hbe00, 16'hfdff, 16'hfe00, 16'hfe01, 16'hfe02, 16'hfe03,
      16'hfe07, 16'hfe0b, 16'hfe0c, 16'hfe0d, 16'hfe0f, 16'hfe10, 16'hff00,
      16'hffc0, 16'hffff};
   logic [7:0] dec_r [20] = '{8'h01, 8'h02, 8'h02, 8'h04, 8'h80, 8'h08,
      8'h08, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
      8'h20, 8'h04, 8'h40, 8'h80};
   logic [8:0] dec_s [20] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h000,
      9'h000, 9'h000, 9'h001, 9'h002, 9'h000, 9'h004, 9'h008, 9'h010,
      9'h020, 9'h040, 9'h080, 9'h000, 9'h000, 9'h000, 9'h100};
   always #12.5 core_clk_i = ~core_clk_i;
   ////////////////////////////////////////
   mmpr_cpu_model cpu_u (.core_clk_i(core_clk_i), .rdata_i(rdata),
      .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
   mmpr_decoder dut_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
      .region_o(region), .sys_sel_o(sys_sel), .illegal_addr_o(illegal),
      .mem_rdata_i(mem_rdata), .sys_rdata_i(sys_rdata),
      .port_a_pin_i((pa_oe & pa_o) | (~pa_oe & pa_ext)), .port_a_pin_o(pa_o),
      .port_a_pin_oe_o(pa_oe),
      .port_b_pin_i((pb_oe & pb_o) | (~pb_oe & pb_ext)), .port_b_pin_o(pb_o),
      .port_b_pin_oe_o(pb_oe),
      .port_c_pin_i((pc_oe & pc_o) | (~pc_oe & pc_ext)), .port_c_pin_o(pc_o),
      .port_c_pin_oe_o(pc_oe), .port_d_pin_i(pd_pin),
      .port_e_latch_o(pe_o), .port_f_latch_o(pf_o));
   ////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      cpu_u.read_byte(a, rd_v);
      check({8'h00, rd_v}, {8'h00, e});
   endtask
   task automatic results;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         results();
      end
   end
   always @(posedge core_clk_i) begin
      if (rd || wr) begin
         ill_q <= illegal;
      end
   end
   initial begin
      repeat (6) @(posedge core_clk_i);
      @(negedge core_clk_i);
      arst_n_i = 1'b1;
      for (int i = 0; i < 20; i++) begin
         cpu_u.show_addr(dec_a[i]);
         #1;
         check({8'h00, region}, {8'h00, dec_r[i]});
         check({7'h00, sys_sel}, {7'h00, dec_s[i]});
      end
      rchk(16'h0006, 8'h00);
      rchk(16'h0008, 8'h00);
      cpu_u.write_byte(16'h0006, 8'hff);
      cpu_u.write_byte(16'h0007, 8'hff);
      cpu_u.write_byte(16'h0008, 8'hff);
      cpu_u.write_byte(16'h0000, 8'ha5);
      cpu_u.write_byte(16'h0001, 8'h5a);
      cpu_u.write_byte(16'h0002, 8'hff);
      cpu_u.write_byte(16'h0004, 8'hc3);
      cpu_u.write_byte(16'h0005, 8'hff);
      cpu_u.write_byte(16'h0003, 8'hff);
      cpu_u.write_byte(16'h0009, 8'hff);
      rchk(16'h0007, 8'hff);
      rchk(16'h0008, 8'h7f);
      rchk(16'h0000, 8'ha5);
      rchk(16'h0001, 8'h5a);
      rchk(16'h0002, 8'h7f);
      rchk(16'h0004, 8'hc3);
      rchk(16'h0005, 8'h3f);
      rchk(16'h0003, 8'h55);
      check({8'h00, pa_o}, 16'h00a5);
      check({8'h00, pb_o}, 16'h005a);
      check({8'h00, pb_oe}, 16'h00ff);
      check({9'h000, pc_o}, 16'h007f);
      check({9'h000, pc_oe}, 16'h007f);
      check({8'h00, pe_o}, 16'h00c3);
      check({10'h000, pf_o}, 16'h003f);
      rchk(16'h0009, 8'h00);
      rchk(16'hfe02, 8'h00);
      check({15'h0000, ill_q}, 16'h0000);
      rchk(16'h0250, 8'h00);
      check({15'h0000, ill_q}, 16'h0001);
      rchk(16'hffc0, 8'h00);
      check({15'h0000, ill_q}, 16'h0000);
      rchk(16'hff00, 8'h00);
      check({15'h0000, ill_q}, 16'h0001);
      rchk(16'hfe0e, 8'h00);
      rchk(16'hfe0f, 8'hee);
      rchk(16'h0050, 8'h99);
      rchk(16'hfe10, 8'h99);
      rchk(16'hffd2, 8'h99);
      rchk(16'hfe00, 8'hee);
      rchk(16'hbe00, 8'h99);
      cpu_u.write_byte(16'h0006, 8'h00);
      pa_ext = 8'h3c;
      repeat (3) @(negedge core_clk_i);
      rchk(16'h0000, 8'h3c);
      @(negedge core_clk_i);
      arst_n_i = 1'b0;
      @(negedge core_clk_i);
      arst_n_i = 1'b1;
      rchk(16'h0007, 8'h00);
      check({8'h00, pa_oe}, 16'h0000);
      check({9'h000, pc_oe}, 16'h0000);
      check({9'h000, pc_o}, 16'h007f);
      cpu_u.write_byte(16'h0006, 8'hff);
      rchk(16'h0000, 8'ha5);
      rchk(16'h0004, 8'hc3);
      rchk(16'h0005, 8'h3f);
      cpu_u.write_byte(16'h0008, 8'hff);
      rchk(16'h0002, 8'h7f);
      results();
   end
endmodule
